/* File: clock_output_and_pll_override.sv */
// auxiliary clock output control and pll strap override registers
// assumes lane clocks, timestamp, reference level and straps are synchronous
`timescale 1ns/1ps
module clock_output_and_pll_override
  import clock_output_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       laneClkDiv16,
  input  wire logic       laneClkDiv32,
  input  wire logic       laneClkDiv64,
  input  wire logic       serdesReinit,
  input  wire logic       timestamp_input,
  output logic            aux_out_pin,
  input  wire logic       pllRefLevel,
  input  wire logic       pllEnablePin,
  input  wire logic       single_ended_ref_pin,
  input  wire logic       clock_config_pin0,
  input  wire logic       clock_config_pin1,
  output logic            pllEnable,
  output logic            single_ended_ref_input,
  output logic            ref_out_c,
  output logic            ref_out_d,
  output logic      [6:0] vcoTrim
);

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0]    auxCtrl_q, auxCtrl_d;
  logic [7:0]    pllOvr_q, pllOvr_d;
  logic [7:0]    vcoTrim_q, vcoTrim_d;
  logic [7:0]    rdData_q, rdData_d;
  aux_state_type auxState_q, auxState_d;
  logic          auxOut_q, auxOut_d;
  logic          stamp_q, stamp_d;
  logic          refDiv1_q, refDiv1_d;
  logic          refDiv2, refDiv4;
  logic          pllEnable_q, pllEnable_d;
  logic          seRef_q, seRef_d;
  logic [2:0]    auxSel;
  logic          overrideMode;
  logic [1:0]    pinCode;
  logic [1:0]    outCSel;
  logic [1:0]    outDSel;

  assign auxSel       = auxCtrl_q[AUX_SEL_HI:AUX_SEL_LO];
  assign overrideMode = pllOvr_q[OVR_ENABLE_BIT];
  assign pinCode      = {clock_config_pin1, clock_config_pin0};

  // register writes; reserved bits are stored as written
  always_comb begin
    auxCtrl_d = auxCtrl_q;
    pllOvr_d  = pllOvr_q;
    vcoTrim_d = vcoTrim_q;
    if (regWrite) begin
      unique case (regAddr)
        AUX_CTRL_ADDR: auxCtrl_d = regWrData;
        PLL_OVR_ADDR:  pllOvr_d  = regWrData;
        VCO_TRIM_ADDR: vcoTrim_d = regWrData;
        default: ;
      endcase
    end
  end

  // read data is registered; reading touches no other state
  always_comb begin
    rdData_d = rdData_q;
    if (regRead) begin
      unique case (regAddr)
        AUX_CTRL_ADDR: rdData_d = auxCtrl_q;
        PLL_OVR_ADDR:  rdData_d = pllOvr_q;
        VCO_TRIM_ADDR: rdData_d = vcoTrim_q;
        default:       rdData_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      auxCtrl_q <= REG_RESET_VALUE;
      pllOvr_q  <= REG_RESET_VALUE;
      vcoTrim_q <= REG_RESET_VALUE;
      rdData_q  <= REG_RESET_VALUE;
    end else begin
      auxCtrl_q <= auxCtrl_d;
      pllOvr_q  <= pllOvr_d;
      vcoTrim_q <= vcoTrim_d;
      rdData_q  <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign vcoTrim   = vcoTrim_q[6:0];

  // ------------------------------------------------------------------
  // auxiliary output
  // ------------------------------------------------------------------
  // hold covers serializer reinit for lane-derived modes only
  always_comb begin
    auxState_d = auxState_q;
    unique case (auxState_q)
      AUX_OFF: begin
        if (auxCtrl_q[AUX_ENABLE_BIT] && serdesReinit && auxSel <= AUX_SEL_UI64) begin
          auxState_d = AUX_HOLD;
        end else if (auxCtrl_q[AUX_ENABLE_BIT]) begin
          auxState_d = AUX_RUN;
        end
      end
      AUX_RUN: begin
        if (!auxCtrl_q[AUX_ENABLE_BIT]) begin
          auxState_d = AUX_OFF;
        end else if (serdesReinit && auxSel <= AUX_SEL_UI64) begin
          auxState_d = AUX_HOLD;
        end
      end
      AUX_HOLD: begin
        if (!auxCtrl_q[AUX_ENABLE_BIT]) begin
          auxState_d = AUX_OFF;
        end else if (!serdesReinit) begin
          auxState_d = AUX_RUN;
        end
      end
      default: auxState_d = AUX_OFF;
    endcase
  end

  // source mux; reserved codes idle low rather than guess a clock
  always_comb begin
    stamp_d  = timestamp_input;
    auxOut_d = 1'b0;
    if (auxState_q == AUX_RUN) begin
      unique case (auxSel)
        AUX_SEL_UI16:  auxOut_d = laneClkDiv16;
        AUX_SEL_UI32:  auxOut_d = laneClkDiv32;
        AUX_SEL_UI64:  auxOut_d = laneClkDiv64;
        AUX_SEL_STAMP: auxOut_d = stamp_q;
        default:       auxOut_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      auxState_q <= AUX_OFF;
      auxOut_q   <= 1'b0;
      stamp_q    <= 1'b0;
    end else begin
      auxState_q <= auxState_d;
      auxOut_q   <= auxOut_d;
      stamp_q    <= stamp_d;
    end
  end

  assign aux_out_pin = auxOut_q;

  // ------------------------------------------------------------------
  // pll strap override and divided reference outputs
  // ------------------------------------------------------------------
  always_comb begin
    refDiv1_d   = pllRefLevel;
    pllEnable_d = overrideMode ? pllOvr_q[PLL_EN_OVR_BIT] : pllEnablePin;
    seRef_d     = overrideMode ? pllOvr_q[SE_REF_OVR_BIT] : single_ended_ref_pin;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      refDiv1_q   <= 1'b0;
      pllEnable_q <= 1'b0;
      seRef_q     <= 1'b0;
    end else begin
      refDiv1_q   <= refDiv1_d;
      pllEnable_q <= pllEnable_d;
      seRef_q     <= seRef_d;
    end
  end

  assign pllEnable              = pllEnable_q;
  assign single_ended_ref_input = seRef_q;

  // pin mode ignores the select fields; d is gated by c in both modes
  always_comb begin
    outCSel = overrideMode ? pllOvr_q[OUT_C_SEL_HI:OUT_C_SEL_LO] : pinCode;
    outDSel = overrideMode ? pllOvr_q[OUT_D_SEL_HI:OUT_D_SEL_LO] : pinCode;
    if (outCSel == REF_SEL_OFF) begin
      outDSel = REF_SEL_OFF;
    end
  end

  ref_clock_divider #(.STAGES(DIV2_STAGES)) divBy2 (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .refLevel (pllRefLevel),
    .divOut   (refDiv2)
  );

  ref_clock_divider #(.STAGES(DIV4_STAGES)) divBy4 (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .refLevel (pllRefLevel),
    .divOut   (refDiv4)
  );

  ref_output_select outC (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .selCode (outCSel),
    .refDiv1 (refDiv1_q),
    .refDiv2 (refDiv2),
    .refDiv4 (refDiv4),
    .refOut  (ref_out_c)
  );

  ref_output_select outD (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .selCode (outDSel),
    .refDiv1 (refDiv1_q),
    .refDiv2 (refDiv2),
    .refDiv4 (refDiv4),
    .refOut  (ref_out_d)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_AUX_OFF: assert property (
    !auxCtrl_q[AUX_ENABLE_BIT] |-> ##2 !aux_out_pin)
    else $error("aux output active while disabled");

  AST_AUX_UI16: assert property (
    (auxState_q == AUX_RUN && auxSel == AUX_SEL_UI16)
      |=> aux_out_pin == $past(laneClkDiv16))
    else $error("aux output not the 16 UI lane clock");

  AST_AUX_UI64: assert property (
    (auxState_q == AUX_RUN && auxSel == AUX_SEL_UI64)
      |=> aux_out_pin == $past(laneClkDiv64))
    else $error("aux output not the 64 UI lane clock");

  AST_AUX_STAMP: assert property (
    (auxState_q == AUX_RUN && auxSel == AUX_SEL_STAMP)
      |=> aux_out_pin == $past(timestamp_input, 2))
    else $error("aux output not the resampled timestamp");

  AST_AUX_REINIT: assert property (
    (serdesReinit && auxSel <= AUX_SEL_UI64) [*2] |=> !aux_out_pin)
    else $error("lane clock not interrupted during reinit");

  AST_PLL_PIN: assert property (
    (!overrideMode && !regWrite) |=> pllEnable == $past(pllEnablePin))
    else $error("pll enable not following strap");

  AST_PLL_OVR: assert property (
    overrideMode |=> pllEnable == $past(pllOvr_q[PLL_EN_OVR_BIT]))
    else $error("pll enable not following override");

  AST_SE_OVR: assert property (
    overrideMode |=> single_ended_ref_input == $past(pllOvr_q[SE_REF_OVR_BIT]))
    else $error("single-ended select not following override");

  AST_C_OFF: assert property (
    (overrideMode && pllOvr_q[OUT_C_SEL_HI:OUT_C_SEL_LO] == REF_SEL_OFF) |=> !ref_out_c)
    else $error("output c running while disabled");

  AST_C_PINS: assert property (
    (!overrideMode && pinCode == REF_SEL_DIV1) |=> ref_out_c == $past(refDiv1_q))
    else $error("output c not following config pins");

  AST_D_DIV2: assert property (
    (overrideMode && outCSel != REF_SEL_OFF
      && pllOvr_q[OUT_D_SEL_HI:OUT_D_SEL_LO] == REF_SEL_DIV2)
      |=> ref_out_d == $past(refDiv2))
    else $error("output d not the divide by 2 reference");

  AST_D_PINS: assert property (
    !overrideMode |-> outDSel == pinCode)
    else $error("output d not following config pins");

  AST_D_GATED: assert property (
    (outCSel == REF_SEL_OFF) |=> !ref_out_d)
    else $error("output d running without output c");

  AST_RESET_ZERO: assert property (
    $rose(reset_n) |-> auxCtrl_q == REG_RESET_VALUE && pllOvr_q == REG_RESET_VALUE)
    else $error("control registers not zero after reset");

  AST_READ_BACK: assert property (
    (regRead && regAddr == PLL_OVR_ADDR) |=> regRdData == $past(pllOvr_q))
    else $error("read data differs from stored value");

  COV_AUX_RUN: cover property (auxState_q == AUX_OFF ##1 auxState_q == AUX_RUN);
  COV_AUX_HOLD: cover property (auxState_q == AUX_RUN ##1 auxState_q == AUX_HOLD);
  COV_OVERRIDE: cover property (overrideMode && outCSel == REF_SEL_DIV4
                                && outDSel == REF_SEL_DIV1);
  COV_PIN_MODE: cover property (!overrideMode && pinCode == REF_SEL_DIV2);

endmodule // clock_output_and_pll_override

/* File: clock_output_pkg.sv */
// constants for the auxiliary clock output and pll pin override block
// assumes one synchronous clock domain and an 8-bit register port
package clock_output_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] AUX_CTRL_ADDR   = 8'h57;
  localparam logic [7:0] PLL_OVR_ADDR    = 8'h58;
  localparam logic [7:0] VCO_TRIM_ADDR   = 8'h59;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int AUX_ENABLE_BIT  = 7;
  localparam int AUX_SEL_HI      = 2;
  localparam int AUX_SEL_LO      = 0;
  localparam int OVR_ENABLE_BIT  = 7;
  localparam int OUT_D_SEL_HI    = 5;
  localparam int OUT_D_SEL_LO    = 4;
  localparam int OUT_C_SEL_HI    = 3;
  localparam int OUT_C_SEL_LO    = 2;
  localparam int SE_REF_OVR_BIT  = 1;
  localparam int PLL_EN_OVR_BIT  = 0;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] AUX_SEL_UI16  = 3'h0;
  localparam logic [2:0] AUX_SEL_UI32  = 3'h1;
  localparam logic [2:0] AUX_SEL_UI64  = 3'h2;
  localparam logic [2:0] AUX_SEL_STAMP = 3'h3;

  localparam logic [1:0] REF_SEL_OFF  = 2'h0;
  localparam logic [1:0] REF_SEL_DIV1 = 2'h1;
  localparam logic [1:0] REF_SEL_DIV2 = 2'h2;
  localparam logic [1:0] REF_SEL_DIV4 = 2'h3;

  // divider stages: divide by 2 and by 4
  localparam int DIV2_STAGES = 1;
  localparam int DIV4_STAGES = 2;

  typedef enum logic [2:0] {
    AUX_OFF  = 3'b001,
    AUX_RUN  = 3'b010,
    AUX_HOLD = 3'b100
  } aux_state_type;

endpackage

/* File: ref_clock_divider.sv */
// divides a sampled reference clock level by a power of two
// assumes refLevel is synchronous to sys_clk and toggles slower than it
`timescale 1ns/1ps
module ref_clock_divider
  import clock_output_pkg::*;
#(
  parameter int STAGES = 1
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic refLevel,
  output logic      divOut
);

  logic              refPrev_q;
  logic              refPrev_d;
  logic [STAGES-1:0] count_q;
  logic [STAGES-1:0] count_d;

  // ------------------------------------------------------------------
  // count rising edges; the top bit is the divided clock
  // ------------------------------------------------------------------
  always_comb begin
    refPrev_d = refLevel;
    count_d   = count_q;
    if (refLevel && !refPrev_q) begin
      count_d = count_q + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      refPrev_q <= 1'b0;
      count_q   <= '0;
    end else begin
      refPrev_q <= refPrev_d;
      count_q   <= count_d;
    end
  end

  assign divOut = count_q[STAGES-1];

endmodule // ref_clock_divider

/* File: ref_output_select.sv */
// picks one divided reference clock for a reference output, or idles it
// assumes the divided clocks are registered levels in the sys_clk domain
`timescale 1ns/1ps
module ref_output_select
  import clock_output_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] selCode,
  input  wire logic       refDiv1,
  input  wire logic       refDiv2,
  input  wire logic       refDiv4,
  output logic            refOut
);

  logic refOut_q;
  logic refOut_d;

  // ------------------------------------------------------------------
  // output mux, registered so the pin never sees a combinational glitch
  // ------------------------------------------------------------------
  always_comb begin
    unique case (selCode)
      REF_SEL_OFF:  refOut_d = 1'b0;
      REF_SEL_DIV1: refOut_d = refDiv1;
      REF_SEL_DIV2: refOut_d = refDiv2;
      REF_SEL_DIV4: refOut_d = refDiv4;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      refOut_q <= 1'b0;
    end else begin
      refOut_q <= refOut_d;
    end
  end

  assign refOut = refOut_q;

endmodule // ref_output_select

/* File: test_clock_output_and_pll_override.sv */
// self-checking bench for the aux clock output and pll override block
// assumes the strobe register port and level-sampled clock inputs, one clock
`timescale 1ns/1ps
module test_clock_output_and_pll_override
  import clock_output_pkg::*;
;
  logic       sys_clk;
  logic       reset_n;
  logic [7:0] regAddr;
  logic       regWrite;
  logic [7:0] regWrData;
  logic       regRead;
  logic [7:0] regRdData;
  logic       laneClkDiv16, laneClkDiv32, laneClkDiv64, timestamp_input;
  logic [3:0] srcBits;
  logic       serdesReinit, aux_out_pin, pllRefLevel, pllEnablePin;
  logic       single_ended_ref_pin, clock_config_pin0, clock_config_pin1;
  logic       pllEnable, single_ended_ref_input, ref_out_c, ref_out_d;
  logic [6:0] vcoTrim;
  logic [7:0] rd;
  logic [2:0] auxSelNow;
  int         num_errors;
  int         comparisons;

  // one vector drives all four aux sources, bit index equals select code
  assign {timestamp_input, laneClkDiv64, laneClkDiv32, laneClkDiv16} = srcBits;

  clock_output_and_pll_override DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .laneClkDiv16(laneClkDiv16), .laneClkDiv32(laneClkDiv32),
    .laneClkDiv64(laneClkDiv64), .serdesReinit(serdesReinit),
    .timestamp_input(timestamp_input), .aux_out_pin(aux_out_pin),
    .pllRefLevel(pllRefLevel), .pllEnablePin(pllEnablePin),
    .single_ended_ref_pin(single_ended_ref_pin), .clock_config_pin0(clock_config_pin0),
    .clock_config_pin1(clock_config_pin1), .pllEnable(pllEnable),
    .single_ended_ref_input(single_ended_ref_input), .ref_out_c(ref_out_c),
    .ref_out_d(ref_out_d), .vcoTrim(vcoTrim));

  // ----------------------------------------------------------------
  // clock and reference level
  // ----------------------------------------------------------------
  // reference toggles every two cycles, so one period is four cycles
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    pllRefLevel = 1'b0;
    forever begin
      repeat (2) @(posedge sys_clk);
      #1 pllRefLevel = ~pllRefLevel;
    end
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    regAddr = addr;
    regWrData = data;
    regWrite = 1'b1;
    @(posedge sys_clk);
    #1 regWrite = 1'b0;
  endtask

  // read data is registered at the read edge, so it is settled 1 ns later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    regAddr = addr;
    regRead = 1'b1;
    @(posedge sys_clk);
    #1 regRead = 1'b0;
    data = regRdData;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // edge counts depend on window phase, so one edge of slack is allowed
  task automatic check_count(input string what, input int exp, input int got);
    comparisons++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic count_edges(input bit useD, output int n);
    logic prev;
    logic cur;
    n = 0;
    prev = useD ? ref_out_d : ref_out_c;
    repeat (64) begin
      @(posedge sys_clk);
      #1;
      cur = useD ? ref_out_d : ref_out_c;
      if (cur === 1'b1 && prev === 1'b0) n++;
      if ($isunknown(cur)) n -= 100; // an unknown output can never pass
      prev = cur;
    end
  endtask

  // expected rising edges in 64 cycles: sixteen reference periods divided
  function automatic int ref_edges(input int code);
    return (code == 0) ? 0 : (16 >> (code - 1));
  endfunction

  task automatic ref_case(input logic [7:0] ovr, input logic [1:0] pins,
                          input int cCode, input int dCode);
    int n;
    write_reg(PLL_OVR_ADDR, ovr);
    {clock_config_pin1, clock_config_pin0} = pins;
    wait_cyc(8);
    count_edges(1'b0, n);
    check_count("ref_out_c edges", ref_edges(cCode), n);
    count_edges(1'b1, n);
    check_count("ref_out_d edges", (cCode == 0) ? 0 : ref_edges(dCode), n);
  endtask

  // select is only changed with the output disabled first
  task automatic aux_case(input logic [2:0] code);
    write_reg(AUX_CTRL_ADDR, {5'h00, auxSelNow});
    write_reg(AUX_CTRL_ADDR, {5'h00, code});
    write_reg(AUX_CTRL_ADDR, {5'h10, code});
    auxSelNow = code;
    srcBits = (code < 3'h4) ? (4'h1 << code) : 4'hf;
    wait_cyc(5);
    check8("aux pin source high", {7'h00, code < 3'h4}, {7'h00, aux_out_pin});
    srcBits = ~srcBits;
    wait_cyc(5);
    check8("aux pin source low", 8'h00, {7'h00, aux_out_pin});
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the sequence needs about 1500 cycles
  // ----------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {regAddr, regWrData, regWrite, regRead} = '0;
    {srcBits, serdesReinit, pllEnablePin, single_ended_ref_pin} = '0;
    {clock_config_pin1, clock_config_pin0} = 2'h0;
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    read_reg(AUX_CTRL_ADDR, rd);
    check8("aux ctrl reset", 8'h00, rd);
    read_reg(PLL_OVR_ADDR, rd);
    check8("pll ovr reset", 8'h00, rd);
    read_reg(VCO_TRIM_ADDR, rd);
    check8("vco trim reset", 8'h00, rd);
    // reserved fields written back as zero, output stays off while disabled
    srcBits = 4'hf;
    write_reg(AUX_CTRL_ADDR, 8'h05);
    auxSelNow = 3'h5;
    write_reg(VCO_TRIM_ADDR, 8'h7f);
    write_reg(8'h5a, 8'h55);
    read_reg(AUX_CTRL_ADDR, rd);
    check8("aux ctrl readback", 8'h05, rd);
    check8("aux pin disabled", 8'h00, {7'h00, aux_out_pin});
    read_reg(VCO_TRIM_ADDR, rd);
    check8("vco trim readback", 8'h7f, rd);
    check8("vco trim out", 8'h7f, {1'b0, vcoTrim});
    read_reg(8'h5a, rd);
    check8("unmapped read", UNMAPPED_READ, rd);
    for (int c = 0; c < 8; c++) aux_case(c[2:0]);
    // enable then disable with every source high
    aux_case(3'h0);
    srcBits = 4'hf;
    wait_cyc(3);
    check8("aux pin enabled", 8'h01, {7'h00, aux_out_pin});
    serdesReinit = 1'b1;
    wait_cyc(3);
    check8("aux pin in reinit", 8'h00, {7'h00, aux_out_pin});
    serdesReinit = 1'b0;
    wait_cyc(4);
    check8("aux pin after reinit", 8'h01, {7'h00, aux_out_pin});
    write_reg(AUX_CTRL_ADDR, 8'h00);
    wait_cyc(3);
    check8("aux pin off", 8'h00, {7'h00, aux_out_pin});
    // timestamp path does not pass through the lane logic
    aux_case(3'h3);
    srcBits = 4'hf;
    serdesReinit = 1'b1;
    wait_cyc(4);
    check8("stamp in reinit", 8'h01, {7'h00, aux_out_pin});
    serdesReinit = 1'b0;
    // strap mode then override with values opposite to the straps
    {pllEnablePin, single_ended_ref_pin} = 2'b11;
    wait_cyc(3);
    check8("pll enable strap", 8'h01, {7'h00, pllEnable});
    check8("se ref strap", 8'h01, {7'h00, single_ended_ref_input});
    write_reg(PLL_OVR_ADDR, 8'h80);
    wait_cyc(2);
    check8("pll enable ovr off", 8'h00, {7'h00, pllEnable});
    check8("se ref ovr off", 8'h00, {7'h00, single_ended_ref_input});
    read_reg(PLL_OVR_ADDR, rd);
    check8("pll ovr readback", 8'h80, rd);
    {pllEnablePin, single_ended_ref_pin} = 2'b00;
    write_reg(PLL_OVR_ADDR, 8'h83);
    wait_cyc(2);
    check8("pll enable ovr on", 8'h01, {7'h00, pllEnable});
    check8("se ref ovr on", 8'h01, {7'h00, single_ended_ref_input});
    ref_case(8'h84, 2'h0, 1, 0);
    ref_case(8'h98, 2'h0, 2, 1);
    ref_case(8'hac, 2'h0, 3, 2);
    ref_case(8'hb4, 2'h0, 1, 3);
    ref_case(8'hb0, 2'h0, 0, 3);
    ref_case(8'h3c, 2'h2, 2, 2);
    ref_case(8'h00, 2'h1, 1, 1);
    ref_case(8'h00, 2'h3, 3, 3);
    ref_case(8'h34, 2'h0, 0, 0);
    complete_run();
  end
endmodule // test_clock_output_and_pll_override
